/* File: design/tmr_pkg.sv */
// Package for the thermal monitor register bank: offsets, reset values, field layout
package tmr_pkg;
   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] OFS_INT_INT = 8'h00;
   localparam logic [7:0] OFS_INT_FRC = 8'h01;
   localparam logic [7:0] OFS_EXT1_INT = 8'h02;
   localparam logic [7:0] OFS_EXT1_FRC = 8'h03;
   localparam logic [7:0] OFS_EXT2_INT = 8'h04;
   localparam logic [7:0] OFS_EXT2_FRC = 8'h05;
   localparam logic [7:0] OFS_EXT3_INT = 8'h06;
   localparam logic [7:0] OFS_EXT3_FRC = 8'h07;
   localparam logic [7:0] OFS_SHDN_LIM = 8'h0a;
   localparam logic [7:0] OFS_PUSH1 = 8'h0c;
   localparam logic [7:0] OFS_PUSH2 = 8'h0d;
   localparam logic [7:0] OFS_TSET_VOLT = 8'h10;
   localparam logic [7:0] OFS_EXT1_IDEAL = 8'h11;
   localparam logic [7:0] OFS_EXT2_IDEAL = 8'h12;
   localparam logic [7:0] OFS_EXT1_BETA = 8'h14;
   localparam logic [7:0] OFS_EXT2_BETA = 8'h15;
   localparam logic [7:0] OFS_SRC_CFG = 8'h17;
   localparam logic [7:0] OFS_EXT1_CRIT = 8'h19;
   localparam logic [7:0] OFS_EXT2_CRIT = 8'h1a;
   localparam logic [7:0] OFS_EXT3_CRIT = 8'h1b;
   localparam logic [7:0] OFS_INT_CRIT = 8'h1d;
   localparam logic [7:0] OFS_CRIT_STAT = 8'h1f;
   localparam logic [7:0] OFS_SHDN_CFG = 8'h20;
   localparam logic [7:0] OFS_CONV_CFG = 8'h21;
   localparam logic [7:0] OFS_LOCK_CFG = 8'h22;
   localparam logic [7:0] OFS_EVT_STAT = 8'h23;
   localparam logic [7:0] OFS_UPPER_STAT = 8'h24;
   localparam logic [7:0] OFS_LOWER_STAT = 8'h25;
   localparam logic [7:0] OFS_FAULT_STAT = 8'h26;
   localparam logic [7:0] OFS_FAN_STAT = 8'h27;
   localparam logic [7:0] OFS_TEMP_MASK = 8'h28;
   localparam logic [7:0] OFS_FAN_MASK = 8'h29;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_TSET_VOLT = 8'hff;
   localparam logic [7:0] RST_IDEAL = 8'h12;
   localparam logic [7:0] RST_BETA = 8'h08;
   localparam logic [7:0] RST_SRC_CFG = 8'h00;
   localparam logic [7:0] RST_CRIT = 8'h64;
   localparam logic [7:0] RST_CONV_CFG = 8'h0e;
   localparam logic [7:0] RST_SHDN_LIM = 8'h64;

   // ***************************************************************
   // Field layout and special values
   // ***************************************************************
   localparam logic [7:0] FAULT_TEMP = 8'h80;   // Reading high byte on a diode fault
   localparam logic [7:0] BETA_WMASK = 8'h1f;   // Writable bits of a beta register
   localparam logic [7:0] SRC_WMASK = 8'h07;    // One enable per external channel
   localparam logic [7:0] SHDN_WMASK = 8'h0f;
   localparam logic [7:0] CHAN_MASK = 8'h0f;    // Bit 0 internal, bits 1..3 ext1..3
   localparam logic [7:0] FAN_WMASK = 8'h07;
   localparam int LOCK_BIT = 0;
   localparam int NCHAN = 4;
endpackage

/* File: design/tmr_regs.sv */
// Register bank of the temperature monitor: readings, limits, configuration and status
//
// Summary of operation
// R1: Every register in the map is host readable, writable ones host writable.
// R2: Unused bits read zero and host writes to them have no effect.
// R3: Single-diode variant: multi-diode registers ignore writes and read 00h.
// R4: Internal reading integer at 00h, fraction at 01h, both reset to zero.
// R5: External diode 1..3 reading pairs at 02h..07h, high byte even.
// R6: Shutdown limit at 0Ah is read only, derived from threshold-set voltage.
// R7: Pushed temperatures at 0Ch, 0Dh reset to zero and feed the lookup table.
// R8: Threshold-set voltage at 10h is read only and reads FFh after reset.
// R9: Ideality registers reset to 12h; second one serves diodes 2 and 3.
// R10: Beta configuration at 14h and 15h obeys the software lock.
// R11: One register at 17h sets series resistance correction for all diodes.
// R12: Critical limits reset to 64h and accept exactly one host write.
// R13: Critical status at 1Fh shows per-channel limit reached, resets zero.
// R14: Configuration at 20h resets 00h and holds shutdown masking options.
// R15: Configuration at 21h sets conversion rate, resets to 0Eh.
// R16: Event status at 23h holds channel event bits, cleared by reading (a fault bit is set again each cycle while its 26h bit is set).
// R17: Upper status 24h and lower status 25h are cleared by reading.
// R18: Diode fault bits 26h and fan status bits 27h clear when read.
// R19: Temperature event mask at 28h, reset 00h, gates the interrupt output.
// R20: Fan event mask at 29h, reset zero, gates fan events onto the interrupt.
// R21: On an open or shorted diode the reading high byte shows 80h.
// R22: Once the software lock is set, lockable registers ignore writes.
`timescale 1ns/100ps
module tmr_regs #(
   // 0 builds the single-diode variant
   parameter bit MULTI_DIODE = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register access from the client interface engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Measurement engine results
   input wire logic meas_valid,
   input wire logic [1:0] meas_chan,
   input wire logic [7:0] meas_int,
   input wire logic [7:0] meas_frac,
   input wire logic meas_fault,
   input wire logic tset_valid,
   input wire logic [7:0] tset_volt,
   input wire logic [7:0] tset_limit,
   // Comparator and fan events, one bit per channel
   input wire logic [3:0] upper_evt,
   input wire logic [3:0] lower_evt,
   input wire logic [2:0] fan_evt,
   // Settings and status to the rest of the device
   output logic [7:0] push_temp_one,
   output logic [7:0] push_temp_two,
   output logic [7:0] ext1_ideality,
   output logic [7:0] ext23_ideality,
   output logic [7:0] ext1_beta,
   output logic [7:0] ext2_beta,
   output logic [7:0] src_cfg,
   output logic [7:0] shdn_cfg,
   output logic [7:0] conv_cfg,
   output logic [31:0] crit_limits,
   output logic [3:0] crit_reached,
   output logic alert
);
   import tmr_pkg::*;

   // ***************************************************************
   // Storage
   // ***************************************************************
   // Reading, limit and one-shot flag per channel, index 0 internal
   logic [7:0] int_r [NCHAN];
   logic [7:0] frc_r [NCHAN];
   logic [7:0] crit_r [NCHAN];
   logic [NCHAN-1:0] crit_done_r;
   logic [7:0] shdn_lim_r, tset_r, push1_r, push2_r;
   logic [7:0] ideal1_r, ideal2_r, beta1_r, beta2_r, src_r;
   logic [7:0] shdn_cfg_r, conv_r, crit_stat_r;
   // Status and mask registers
   logic [7:0] evt_r, upper_r, lower_r, fault_r, fan_r, tmask_r, fmask_r;
   logic lock_r;
   logic [7:0] rdata_nxt;
   logic [3:0] crit_hit;
   logic multi_ok;
   logic [7:0] flt_set;

   // Multi-diode offsets are dead on the single-diode build
   function automatic logic is_multi(input logic [7:0] a);
      return a == OFS_EXT2_INT || a == OFS_EXT2_FRC || a == OFS_EXT3_INT ||
             a == OFS_EXT3_FRC || a == OFS_EXT2_IDEAL || a == OFS_EXT2_BETA ||
             a == OFS_EXT2_CRIT || a == OFS_EXT3_CRIT;
   endfunction

   // Channel index to critical limit offset
   function automatic logic [7:0] crit_ofs(input int c);
      case (c)
         0: return OFS_INT_CRIT;
         1: return OFS_EXT1_CRIT;
         2: return OFS_EXT2_CRIT;
         default: return OFS_EXT3_CRIT;
      endcase
   endfunction

   // Gate for every host access on the single-diode build
   assign multi_ok = MULTI_DIODE || !is_multi(reg_addr); // [R3]

   // ***************************************************************
   // Temperature readings
   // ***************************************************************
   // A fault forces the high byte; the fraction is held at zero meanwhile
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NCHAN; i++) begin
            int_r[i] <= RST_ZERO; // [R4] [R5]
            frc_r[i] <= RST_ZERO;
         end
      end else if (meas_valid && (MULTI_DIODE || meas_chan < 2'd2)) begin
         if (meas_fault) begin
            int_r[meas_chan] <= FAULT_TEMP; // [R21]
            frc_r[meas_chan] <= RST_ZERO;
         end else begin
            int_r[meas_chan] <= meas_int;
            frc_r[meas_chan] <= meas_frac;
         end
      end
   end

   // Threshold-set voltage and the limit derived from it, never host written
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tset_r <= RST_TSET_VOLT; // [R8]
         shdn_lim_r <= RST_SHDN_LIM;
      end else if (tset_valid) begin
         tset_r <= tset_volt;
         shdn_lim_r <= tset_limit; // [R6]
      end
   end

   // ***************************************************************
   // Host writable configuration
   // ***************************************************************
   // Lock is sticky: only a reset releases it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_r <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_LOCK_CFG && reg_wdata[LOCK_BIT]) begin
         lock_r <= 1'b1; // [R22]
      end
   end

   // Registers with no lock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         push1_r <= RST_ZERO; // [R7]
         push2_r <= RST_ZERO;
         tmask_r <= RST_ZERO; // [R19]
         fmask_r <= RST_ZERO; // [R20]
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_PUSH1: push1_r <= reg_wdata; // [R1]
            OFS_PUSH2: push2_r <= reg_wdata;
            OFS_TEMP_MASK: tmask_r <= reg_wdata & CHAN_MASK; // [R2]
            OFS_FAN_MASK: fmask_r <= reg_wdata & FAN_WMASK;
            default: ;
         endcase
      end
   end

   // Lockable registers; writes after the lock are dropped silently
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ideal1_r <= RST_IDEAL; // [R9]
         ideal2_r <= RST_IDEAL;
         beta1_r <= RST_BETA;
         beta2_r <= RST_BETA;
         src_r <= RST_SRC_CFG;
         shdn_cfg_r <= RST_ZERO; // [R14]
         conv_r <= RST_CONV_CFG; // [R15]
      end else if (reg_wr && !lock_r && multi_ok) begin // [R22]
         unique case (reg_addr)
            OFS_EXT1_IDEAL: ideal1_r <= reg_wdata;
            OFS_EXT2_IDEAL: ideal2_r <= reg_wdata;
            OFS_EXT1_BETA: beta1_r <= reg_wdata & BETA_WMASK; // [R10] [R2]
            OFS_EXT2_BETA: beta2_r <= reg_wdata & BETA_WMASK; // [R10]
            OFS_SRC_CFG: src_r <= reg_wdata & SRC_WMASK; // [R11]
            OFS_SHDN_CFG: shdn_cfg_r <= reg_wdata & SHDN_WMASK;
            OFS_CONV_CFG: conv_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Critical limits: one write each, then fixed until reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NCHAN; i++) begin
            crit_r[i] <= RST_CRIT; // [R12]
            crit_done_r[i] <= 1'b0;
         end
      end else begin
         for (int i = 0; i < NCHAN; i++) begin
            // A refused second write leaves value and flag untouched
            if (reg_wr && multi_ok && reg_addr == crit_ofs(i) && !crit_done_r[i]) begin
               crit_r[i] <= reg_wdata; // [R12]
               crit_done_r[i] <= 1'b1;
            end
         end
      end
   end

   // ***************************************************************
   // Status
   // ***************************************************************
   // Limit reached when the reading is valid and at or above its limit
   always_comb begin
      for (int i = 0; i < NCHAN; i++) begin
         crit_hit[i] = (int_r[i] != FAULT_TEMP) && (int_r[i] >= crit_r[i]);
      end
      // Channels missing on the single-diode build never report
      if (!MULTI_DIODE) begin
         crit_hit[3:2] = 2'b00;
      end
   end

   // Critical status follows the comparison directly
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         crit_stat_r <= RST_ZERO; // [R13]
      end else begin
         crit_stat_r <= {4'h0, crit_hit}; // [R13]
      end
   end

   // Fault events of this cycle, one bit per channel present on this build
   always_comb begin
      flt_set = RST_ZERO;
      if (meas_valid && meas_fault && (MULTI_DIODE || meas_chan < 2'd2)) begin
         flt_set[meas_chan] = 1'b1; // [R21]
      end
   end

   // Upper limit status; an event in the read cycle survives the clear (set wins)
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upper_r <= RST_ZERO;
      end else begin
         upper_r <= ((reg_rd && reg_addr == OFS_UPPER_STAT) ? RST_ZERO : upper_r)
                    | {4'h0, upper_evt}; // [R17]
      end
   end

   // Lower limit status, same read-clear rule
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lower_r <= RST_ZERO;
      end else begin
         lower_r <= ((reg_rd && reg_addr == OFS_LOWER_STAT) ? RST_ZERO : lower_r)
                    | {4'h0, lower_evt}; // [R17]
      end
   end

   // Diode fault status; a bit stays until read even if the diode recovers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_r <= RST_ZERO;
      end else begin
         fault_r <= ((reg_rd && reg_addr == OFS_FAULT_STAT) ? RST_ZERO : fault_r)
                    | (flt_set & CHAN_MASK); // [R18] [R21]
      end
   end

   // Fan status, same read-clear rule
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fan_r <= RST_ZERO;
      end else begin
         fan_r <= ((reg_rd && reg_addr == OFS_FAN_STAT) ? RST_ZERO : fan_r)
                  | {5'h00, fan_evt}; // [R18]
      end
   end

   // Event status collects upper, lower and diode fault events per channel; fan events stay out
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_r <= RST_ZERO;
      end else begin
         evt_r <= ((reg_rd && reg_addr == OFS_EVT_STAT) ? RST_ZERO : evt_r)
                  | ({4'h0, upper_evt | lower_evt} | (fault_r & CHAN_MASK)
                     & {4'h0, 4'hf} & 8'h0f); // [R16]
      end
   end

   // Alert is registered so it never glitches on a bus read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         alert <= 1'b0;
      end else begin
         alert <= |(evt_r & tmask_r) || |(fan_r & fmask_r); // [R19] [R20]
      end
   end

   // ***************************************************************
   // Read path
   // ***************************************************************
   // Offset decode; unknown offsets and dead offsets read zero
   always_comb begin
      rdata_nxt = RST_ZERO; // [R2]
      unique case (reg_addr)
         OFS_INT_INT: rdata_nxt = int_r[0]; // [R4]
         OFS_INT_FRC: rdata_nxt = frc_r[0];
         OFS_EXT1_INT: rdata_nxt = int_r[1]; // [R5]
         OFS_EXT1_FRC: rdata_nxt = frc_r[1];
         OFS_EXT2_INT: rdata_nxt = int_r[2];
         OFS_EXT2_FRC: rdata_nxt = frc_r[2];
         OFS_EXT3_INT: rdata_nxt = int_r[3];
         OFS_EXT3_FRC: rdata_nxt = frc_r[3];
         OFS_SHDN_LIM: rdata_nxt = shdn_lim_r;
         OFS_PUSH1: rdata_nxt = push1_r;
         OFS_PUSH2: rdata_nxt = push2_r;
         OFS_TSET_VOLT: rdata_nxt = tset_r;
         OFS_EXT1_IDEAL: rdata_nxt = ideal1_r;
         OFS_EXT2_IDEAL: rdata_nxt = ideal2_r;
         OFS_EXT1_BETA: rdata_nxt = beta1_r;
         OFS_EXT2_BETA: rdata_nxt = beta2_r;
         OFS_SRC_CFG: rdata_nxt = src_r;
         OFS_EXT1_CRIT: rdata_nxt = crit_r[1];
         OFS_EXT2_CRIT: rdata_nxt = crit_r[2];
         OFS_EXT3_CRIT: rdata_nxt = crit_r[3];
         OFS_INT_CRIT: rdata_nxt = crit_r[0];
         OFS_CRIT_STAT: rdata_nxt = crit_stat_r;
         OFS_SHDN_CFG: rdata_nxt = shdn_cfg_r;
         OFS_CONV_CFG: rdata_nxt = conv_r;
         OFS_LOCK_CFG: rdata_nxt = {7'h00, lock_r};
         OFS_EVT_STAT: rdata_nxt = evt_r; // [R16]
         OFS_UPPER_STAT: rdata_nxt = upper_r;
         OFS_LOWER_STAT: rdata_nxt = lower_r;
         OFS_FAULT_STAT: rdata_nxt = fault_r;
         OFS_FAN_STAT: rdata_nxt = fan_r;
         OFS_TEMP_MASK: rdata_nxt = tmask_r;
         OFS_FAN_MASK: rdata_nxt = fmask_r;
         default: rdata_nxt = RST_ZERO;
      endcase
      if (!multi_ok) begin
         rdata_nxt = RST_ZERO; // [R3]
      end
   end

   // Read data is captured on the strobe and held until the next read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= RST_ZERO;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt; // [R1]
      end
   end

   // ***************************************************************
   // Settings out
   // ***************************************************************
   // Settings go out straight from the flip-flops
   assign push_temp_one = push1_r;
   assign push_temp_two = push2_r;
   assign ext1_ideality = ideal1_r;
   assign ext23_ideality = ideal2_r; // [R9]
   assign ext1_beta = beta1_r;
   assign ext2_beta = beta2_r;
   assign src_cfg = src_r;
   assign shdn_cfg = shdn_cfg_r;
   assign conv_cfg = conv_r;
   assign crit_limits = {crit_r[3], crit_r[2], crit_r[1], crit_r[0]};
   assign crit_reached = crit_stat_r[3:0];
endmodule

/* File: sim/tmr_host.sv */
// Host model: issues register reads and writes to the bank
`timescale 1ns/100ps
module tmr_host (
   // Clock
   input wire logic clk,
   // Register access
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One-cycle write; released fields flip so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // One-cycle read; data is registered at the strobe's edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

/* File: sim/tmr_regs_props.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
module tmr_regs_chk
   import tmr_pkg::*;
#(
   parameter bit MULTI_DIODE = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Events
   input wire logic meas_valid,
   input wire logic [3:0] upper_evt,
   input wire logic [3:0] lower_evt,
   input wire logic [2:0] fan_evt,
   // Settings and status
   input wire logic [7:0] push_temp_one,
   input wire logic [7:0] ext1_beta,
   input wire logic [7:0] src_cfg,
   input wire logic [7:0] shdn_cfg,
   input wire logic [31:0] crit_limits,
   input wire logic alert
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic crit1_done_r;
   logic cause;
   // Anything that may legally raise the alert level
   assign cause = reg_wr | meas_valid | (|upper_evt) | (|lower_evt) | (|fan_evt);
   // Remembers the first write of the ext1 critical limit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         crit1_done_r <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_EXT1_CRIT) begin
         crit1_done_r <= 1'b1;
      end
   end
   sequence rd_upper_s;
      reg_rd && reg_addr == OFS_UPPER_STAT && upper_evt == 4'h0;
   endsequence
   sequence quiet_s;
      !reg_rd && upper_evt == 4'h0;
   endsequence
   rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   push_wr_a: assert property (reg_wr && reg_addr == OFS_PUSH1
      |=> push_temp_one == $past(reg_wdata)) else $error("push write lost");
   push_rd_a: assert property (reg_rd && !reg_wr && reg_addr == OFS_PUSH1
      |=> reg_rdata == $past(push_temp_one)) else $error("push read wrong");
   unmapped_zero_a: assert property (reg_rd && reg_addr inside
      {8'h08, 8'h09, 8'h0b, 8'h0e, 8'h0f, 8'h13, 8'h16} |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   unused_bits_a: assert property ((ext1_beta & ~BETA_WMASK) == 8'h00
      && (src_cfg & ~SRC_WMASK) == 8'h00 && (shdn_cfg & ~SHDN_WMASK) == 8'h00)
      else $error("unused setting bit set");
   crit_once_a: assert property (crit1_done_r && reg_wr && reg_addr == OFS_EXT1_CRIT
      |=> $stable(crit_limits[15:8])) else $error("critical limit rewritten");
   upper_clear_a: assert property (rd_upper_s ##1 quiet_s ##1 rd_upper_s
      |=> reg_rdata == 8'h00) else $error("upper status not cleared");
   alert_cause_a: assert property ($rose(alert)
      |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
      else $error("alert without cause");
endmodule

bind tmr_regs tmr_regs_chk #(.MULTI_DIODE(MULTI_DIODE)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .meas_valid(meas_valid), .upper_evt(upper_evt), .lower_evt(lower_evt),
   .fan_evt(fan_evt), .push_temp_one(push_temp_one), .ext1_beta(ext1_beta),
   .src_cfg(src_cfg), .shdn_cfg(shdn_cfg), .crit_limits(crit_limits), .alert(alert)
);

/* File: sim/tb_top.sv */
// Testbench top: register bank tests through the host model
`timescale 1ns/100ps
module tb_top;
   import tmr_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr, reg_rd, meas_valid, meas_fault, tset_valid, alert;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, meas_int, meas_frac, tset_volt, tset_limit;
   logic [7:0] push_temp_one, push_temp_two, ext1_ideality, ext23_ideality, rd_v;
   logic [7:0] ext1_beta, ext2_beta, src_cfg, shdn_cfg, conv_cfg;
   logic [1:0] meas_chan;
   logic [3:0] upper_evt, lower_evt, crit_reached;
   logic [2:0] fan_evt;
   logic [31:0] crit_limits;
   logic [7:0] sd_rdata, sd_ideal;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   // Address and expected value pairs
   localparam logic [15:0] RV [32] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300,
      16'h0400, 16'h0500, 16'h0600, 16'h0700, 16'h0800, 16'h0a64, 16'h0c00, 16'h0d00,
      16'h10ff, 16'h1112, 16'h1212, 16'h1408, 16'h1508, 16'h1700, 16'h1964, 16'h1a64,
      16'h1b64, 16'h1d64, 16'h1f00, 16'h2000, 16'h210e, 16'h2300, 16'h2400, 16'h2500,
      16'h2600, 16'h2700, 16'h2800, 16'h2900};
   localparam logic [15:0] WI [5] = '{16'h0000, 16'h0a64, 16'h10ff, 16'h0800, 16'h1f00};
   localparam logic [15:0] MK [5] = '{16'h141f, 16'h1707, 16'h200f, 16'h280f, 16'h2907};

   tmr_host u_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
   tmr_regs #(.MULTI_DIODE(1'b1)) u_dut (
      .clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .meas_valid, .meas_chan, .meas_int, .meas_frac, .meas_fault,
      .tset_valid, .tset_volt, .tset_limit, .upper_evt, .lower_evt, .fan_evt,
      .push_temp_one, .push_temp_two, .ext1_ideality, .ext23_ideality,
      .ext1_beta, .ext2_beta, .src_cfg, .shdn_cfg, .conv_cfg, .crit_limits,
      .crit_reached, .alert
   );
   // Single-diode build on the same bus, to see dead offsets
   tmr_regs #(.MULTI_DIODE(1'b0)) u_dut_single (
      .clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata(sd_rdata),
      .meas_valid, .meas_chan, .meas_int, .meas_frac, .meas_fault,
      .tset_valid, .tset_volt, .tset_limit, .upper_evt, .lower_evt, .fan_evt,
      .push_temp_one(), .push_temp_two(), .ext1_ideality(), .ext23_ideality(sd_ideal),
      .ext1_beta(), .ext2_beta(), .src_cfg(), .shdn_cfg(), .conv_cfg(), .crit_limits(),
      .crit_reached(), .alert()
   );
   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Hang guard: the tests need well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, rd_v);
      chk(rd_v, exp);
   endtask
   task automatic nxt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One measurement result pulse
   task automatic meas(input logic [1:0] c, input logic [7:0] i, input logic flt);
      nxt(1);
      {meas_valid, meas_chan, meas_int, meas_frac, meas_fault} = {1'b1, c, i, i + 8'h10, flt};
      nxt(1);
      meas_valid = 1'b0;
   endtask
   // One pulse of comparator and fan events
   task automatic evt(input logic [3:0] u, input logic [3:0] l, input logic [2:0] f);
      nxt(1);
      {upper_evt, lower_evt, fan_evt} = {u, l, f};
      nxt(1);
      {upper_evt, lower_evt, fan_evt} = 11'h000;
   endtask
   // Main sequence
   initial begin
      {meas_valid, meas_fault, tset_valid, meas_chan} = 5'h00;
      {meas_int, meas_frac, tset_volt, tset_limit} = 32'h0000_0000;
      {upper_evt, lower_evt, fan_evt} = 11'h000;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      for (int i = 0; i < 32; i++) rchk(RV[i][15:8], RV[i][7:0]);
      chk(conv_cfg, 8'h0e);
      for (int i = 0; i < 5; i++) begin
         u_host.wr(WI[i][15:8], 8'hff);
         rchk(WI[i][15:8], WI[i][7:0]);
      end
      for (int i = 0; i < 4; i++) begin
         meas(2'(i), 8'h10 + 8'(i), 1'b0);
         rchk(8'(2 * i), 8'h10 + 8'(i));
         chk(sd_rdata, (i < 2) ? 8'h10 + 8'(i) : 8'h00);
         rchk(8'(2 * i + 1), 8'h20 + 8'(i));
      end
      nxt(1);
      {tset_valid, tset_volt, tset_limit} = {1'b1, 16'h5a3c};
      nxt(1);
      tset_valid = 1'b0;
      rchk(OFS_TSET_VOLT, 8'h5a);
      rchk(OFS_SHDN_LIM, 8'h3c);
      u_host.wr(OFS_EXT1_CRIT, 8'h20);
      u_host.wr(OFS_EXT1_CRIT, 8'h30);
      rchk(OFS_EXT1_CRIT, 8'h20);
      chk(crit_limits[15:8], 8'h20);
      meas(2'h1, 8'h25, 1'b0);
      rchk(OFS_CRIT_STAT, 8'h02);
      chk({4'h0, crit_reached}, 8'h02);
      evt(4'h4, 4'h1, 3'h2);
      chk({7'h00, alert}, 8'h00);
      u_host.wr(OFS_TEMP_MASK, 8'h0f);
      nxt(1);
      chk({7'h00, alert}, 8'h01);
      rchk(OFS_EVT_STAT, 8'h05);
      rchk(OFS_UPPER_STAT, 8'h04);
      rchk(OFS_UPPER_STAT, 8'h00);
      rchk(OFS_LOWER_STAT, 8'h01);
      rchk(OFS_FAN_STAT, 8'h02);
      rchk(OFS_FAN_STAT, 8'h00);
      nxt(1);
      chk({7'h00, alert}, 8'h00);
      evt(4'h0, 4'h0, 3'h1);
      u_host.wr(OFS_FAN_MASK, 8'h07);
      nxt(1);
      chk({7'h00, alert}, 8'h01);
      rchk(OFS_FAN_STAT, 8'h01);
      nxt(1);
      chk({7'h00, alert}, 8'h00);
      for (int i = 0; i < 5; i++) begin
         u_host.wr(MK[i][15:8], 8'hff);
         rchk(MK[i][15:8], MK[i][7:0]);
      end
      chk(ext1_beta, 8'h1f);
      chk(ext2_beta, 8'h08);
      chk(src_cfg, 8'h07);
      chk(shdn_cfg, 8'h0f);
      u_host.wr(OFS_PUSH1, 8'h55);
      u_host.wr(OFS_PUSH2, 8'haa);
      rchk(OFS_PUSH1, 8'h55);
      chk(push_temp_two, 8'haa);
      meas(2'h1, 8'h33, 1'b1);
      rchk(OFS_EXT1_INT, 8'h80);
      rchk(OFS_FAULT_STAT, 8'h02);
      rchk(OFS_FAULT_STAT, 8'h00);
      u_host.wr(OFS_EXT2_IDEAL, 8'h1c);
      chk(ext23_ideality, 8'h1c);
      chk(sd_ideal, 8'h12);
      u_host.wr(OFS_LOCK_CFG, 8'h01);
      u_host.wr(OFS_EXT1_IDEAL, 8'h33);
      rchk(OFS_EXT1_IDEAL, 8'h12);
      chk(ext1_ideality, 8'h12);
      u_host.wr(OFS_SRC_CFG, 8'h00);
      rchk(OFS_SRC_CFG, 8'h07);
      u_host.wr(OFS_PUSH2, 8'h77);
      rchk(OFS_PUSH2, 8'h77);
      print_verdict();
   end
endmodule
